//--- logic/uart_receive_config_status.sv
`timescale 1ns/10ps
module uart_receive_config_status (
	input wire logic clk, // 100 MHz clock
	input wire logic rst, // async reset, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wr_data, // write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	output logic [31:0] rd_data, // read data, cycle after the strobe
	input wire logic serial_receive_line, // receive pin
	input wire logic tx_loop_line, // transmitter output for loopback
	input wire logic baud_tick, // one pulse per baud clock tick
	output logic rx_irq_flag, // receive interrupt level
	output logic irq // masked event interrupt level
);
	typedef enum logic [2:0] {st_idle, st_start, st_data, st_parity, st_stop} rx_state_t;
	localparam int BUF_DEPTH = uart_rx_pkg::BUF_DEPTH;

	rx_state_t st_ff;
	logic [6:0] mode_ff;
	logic [1:0] rxisel_ff;
	logic address_detect_enable_ff, ovr_ff;
	logic [3:0] tk_ff, bc_ff;
	logic [8:0] shift_ff;
	logic par_ff, fe_ff;
	logic [10:0] buf_ff [BUF_DEPTH];
	logic [1:0] wp_ff, rp_ff;
	logic [2:0] cnt_ff;
	logic line_prev_ff, ab_meas_ff, ab_tail_ff;
	logic [2:0] ab_edges_ff;
	logic [uart_rx_pkg::MEAS_W-1:0] ab_cnt_ff, baud_ff;
	logic [uart_rx_pkg::EV_W-1:0] ist_ff, imask_ff;
	logic [31:0] rd_data_ff;
	logic rx_irq_ff, irq_ff;

	// per-bit tick top, one function for full and half bit
	function automatic logic [3:0] tick_top(input logic high_speed_select, input logic half);
		if (half)
			return high_speed_select ? uart_rx_pkg::TK_HALF_4X : uart_rx_pkg::TK_HALF_16X;
		return high_speed_select ? uart_rx_pkg::TK_TOP_4X : uart_rx_pkg::TK_TOP_16X;
	endfunction

	// fill test against the selected interrupt mode
	function automatic logic level_met(input logic [1:0] sel, input logic [2:0] n);
		case (sel)
			uart_rx_pkg::RXI_3Q: return n >= uart_rx_pkg::LVL_3Q;
			uart_rx_pkg::RXI_HALF: return n >= uart_rx_pkg::LVL_HALF;
			default: return n >= uart_rx_pkg::LVL_ONE; // reserved code acts as not-empty
		endcase
	endfunction

	// field decode
	logic loopback, auto_baud_enable, receive_polarity_invert, high_speed_select, stop_count_select, nine_bit, has_par, odd_par;
	logic [1:0] data_parity_select;
	assign loopback = mode_ff[uart_rx_pkg::MODE_LOOPBACK];
	assign auto_baud_enable = mode_ff[uart_rx_pkg::MODE_AUTO_BAUD_ENABLE];
	assign receive_polarity_invert = mode_ff[uart_rx_pkg::MODE_RECEIVE_POLARITY_INVERT];
	assign high_speed_select = mode_ff[uart_rx_pkg::MODE_HIGH_SPEED_SELECT];
	assign data_parity_select = mode_ff[uart_rx_pkg::MODE_DATA_PARITY_SELECT_HI:uart_rx_pkg::MODE_DATA_PARITY_SELECT_LO];
	assign stop_count_select = mode_ff[uart_rx_pkg::MODE_STOP_COUNT_SELECT];
	assign nine_bit = (data_parity_select == uart_rx_pkg::FMT_9N);
	assign has_par = (data_parity_select == uart_rx_pkg::FMT_8O) || (data_parity_select == uart_rx_pkg::FMT_8E);
	assign odd_par = (data_parity_select == uart_rx_pkg::FMT_8O);

	// line source and polarity; after this, 1 is always idle
	logic line_src, line_n;
	assign line_src = loopback ? tx_loop_line : serial_receive_line;
	assign line_n = receive_polarity_invert ? ~line_src : line_src;

	// bus strobes
	logic mode_wr, sta_wr, rxd_rd, ist_wr, imask_wr;
	assign mode_wr = ce && wr_en && (addr == uart_rx_pkg::OFF_MODE);
	assign sta_wr = ce && wr_en && (addr == uart_rx_pkg::OFF_STATUS);
	assign ist_wr = ce && wr_en && (addr == uart_rx_pkg::OFF_INT_STATUS);
	assign imask_wr = ce && wr_en && (addr == uart_rx_pkg::OFF_INT_MASK);
	assign rxd_rd = ce && rd_en && (addr == uart_rx_pkg::OFF_RXDATA);

	// receiver timing
	logic tick_last, half_last, ch_done, ovr_clear_go, fall, ab_done;
	logic [3:0] last_bit, last_stop;
	assign tick_last = baud_tick && (tk_ff == tick_top(high_speed_select, 1'b0));
	assign half_last = baud_tick && (tk_ff == tick_top(high_speed_select, 1'b1));
	assign last_bit = nine_bit ? 4'h8 : 4'h7;
	assign last_stop = stop_count_select ? 4'h1 : 4'h0;
	assign ch_done = ce && (st_ff == st_stop) && tick_last && (bc_ff == last_stop);
	// a stray 1 written to the overrun bit never sets it
	assign ovr_clear_go = sta_wr && ovr_ff && !wr_data[uart_rx_pkg::STA_OVR];
	assign fall = line_prev_ff && !line_n;
	assign ab_done = ce && ab_meas_ff && fall
		&& (ab_edges_ff == uart_rx_pkg::AUTO_BAUD_ENABLE_LAST_EDGE - 3'h1);

	// completed character and its checks
	logic stop_bad, par_bad, addr_skip, push, overflow;
	assign stop_bad = !line_n;
	assign par_bad = has_par && ((^shift_ff[7:0] ^ par_ff) != odd_par);
	assign addr_skip = address_detect_enable_ff && nine_bit && !shift_ff[8];
	assign push = ch_done && !addr_skip && (cnt_ff != uart_rx_pkg::LVL_FULL);
	assign overflow = ch_done && !addr_skip && (cnt_ff == uart_rx_pkg::LVL_FULL);

	logic pop;
	assign pop = rxd_rd && (cnt_ff != 3'h0);

	// mode register; a software write wins over the hardware clear of auto-baud
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mode_ff <= 7'h00;
		else if (mode_wr)
			mode_ff <= wr_data[6:0];
		else if (ab_done)
			mode_ff[uart_rx_pkg::MODE_AUTO_BAUD_ENABLE] <= 1'b0;
	end

	// status control writable fields
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rxisel_ff <= 2'h0;
			address_detect_enable_ff <= 1'b0;
		end
		else if (sta_wr)
		begin
			rxisel_ff <= wr_data[uart_rx_pkg::STA_RXISEL_HI:uart_rx_pkg::STA_RXISEL_LO];
			address_detect_enable_ff <= wr_data[uart_rx_pkg::STA_ADDRESS_DETECT_ENABLE];
		end
	end

	// overrun: hardware sets, software alone clears; a set beats the clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ovr_ff <= 1'b0;
		else if (overflow)
			ovr_ff <= 1'b1;
		else if (ovr_clear_go)
			ovr_ff <= 1'b0;
	end

	// receive state machine; held idle while auto-baud owns the line
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= st_idle;
			tk_ff <= 4'h0;
			bc_ff <= 4'h0;
			shift_ff <= 9'h000;
			par_ff <= 1'b0;
			fe_ff <= 1'b0;
		end
		else if (ovr_clear_go && !overflow)
		begin
			st_ff <= st_idle;
			tk_ff <= 4'h0;
			bc_ff <= 4'h0;
			shift_ff <= 9'h000;
			par_ff <= 1'b0;
			fe_ff <= 1'b0;
		end
		else if (ce)
		begin
			case (st_ff)
				st_idle:
				begin
					tk_ff <= 4'h0;
					bc_ff <= 4'h0;
					fe_ff <= 1'b0;
					if (!line_n && !auto_baud_enable && !ab_meas_ff && !ab_tail_ff)
					begin
						st_ff <= st_start;
						shift_ff <= 9'h000;
					end
				end
				st_start:
					if (half_last)
					begin
						tk_ff <= 4'h0;
						// a glitch shorter than half a bit is not a start
						st_ff <= line_n ? st_idle : st_data;
					end
					else if (baud_tick)
						tk_ff <= tk_ff + 4'h1;
				st_data:
					if (tick_last)
					begin
						tk_ff <= 4'h0;
						shift_ff[bc_ff] <= line_n;
						if (bc_ff == last_bit)
						begin
							bc_ff <= 4'h0;
							st_ff <= has_par ? st_parity : st_stop;
						end
						else
							bc_ff <= bc_ff + 4'h1;
					end
					else if (baud_tick)
						tk_ff <= tk_ff + 4'h1;
				st_parity:
					if (tick_last)
					begin
						tk_ff <= 4'h0;
						par_ff <= line_n;
						st_ff <= st_stop;
					end
					else if (baud_tick)
						tk_ff <= tk_ff + 4'h1;
				st_stop:
					if (tick_last)
					begin
						tk_ff <= 4'h0;
						if (stop_bad)
							fe_ff <= 1'b1;
						if (bc_ff == last_stop)
							st_ff <= st_idle;
						else
							bc_ff <= bc_ff + 4'h1;
					end
					else if (baud_tick)
						tk_ff <= tk_ff + 4'h1;
				default:
					st_ff <= st_idle;
			endcase
		end
	end

	// buffer storage: error flags ride with each character
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_ff[i] <= 11'h000;
		end
		else if (push)
			buf_ff[wp_ff] <= {fe_ff | stop_bad, par_bad, shift_ff};
	end

	// buffer pointers and fill; overrun clear flushes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_ff <= 2'h0;
			rp_ff <= 2'h0;
			cnt_ff <= 3'h0;
		end
		else if (ovr_clear_go && !overflow)
		begin
			wp_ff <= 2'h0;
			rp_ff <= 2'h0;
			cnt_ff <= 3'h0;
		end
		else if (ce)
		begin
			if (push)
				wp_ff <= wp_ff + 2'h1;
			if (pop)
				rp_ff <= rp_ff + 2'h1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 3'h1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 3'h1;
		end
	end

	// auto-baud: count clocks from the start edge to the fifth falling edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			line_prev_ff <= 1'b1;
			ab_meas_ff <= 1'b0;
			ab_tail_ff <= 1'b0;
			ab_edges_ff <= 3'h0;
			ab_cnt_ff <= '0;
			baud_ff <= '0;
		end
		else if (ce)
		begin
			line_prev_ff <= line_n;
			if (ab_done)
			begin
				ab_meas_ff <= 1'b0;
				ab_tail_ff <= 1'b1;
				baud_ff <= ab_cnt_ff;
			end
			else if (ab_meas_ff)
			begin
				if (fall)
					ab_edges_ff <= ab_edges_ff + 3'h1;
				if (ab_cnt_ff != '1)
					ab_cnt_ff <= ab_cnt_ff + 1'b1;
			end
			else if (auto_baud_enable && st_ff == st_idle && fall)
			begin
				ab_meas_ff <= 1'b1;
				ab_edges_ff <= 3'h1;
				ab_cnt_ff <= '0;
			end
			// the last low bit of the sync must not look like a start
			if (ab_tail_ff && line_n)
				ab_tail_ff <= 1'b0;
		end
	end

	// current character views
	logic [10:0] head;
	logic idle_flag, parity_error_flag_flag, framing_error_flag_flag, avail;
	assign head = buf_ff[rp_ff];
	assign avail = (cnt_ff != 3'h0);
	assign parity_error_flag_flag = avail && head[9];
	assign framing_error_flag_flag = avail && head[10];
	assign idle_flag = (st_ff == st_idle) && !ab_meas_ff && !ab_tail_ff;

	// event status, write one to clear; a new event beats the clear
	logic [uart_rx_pkg::EV_W-1:0] ev;
	always_comb
	begin
		ev = '0;
		ev[uart_rx_pkg::EV_RX_LEVEL] = ce && level_met(rxisel_ff, cnt_ff);
		ev[uart_rx_pkg::EV_PARITY_ERROR_FLAG] = push && par_bad;
		ev[uart_rx_pkg::EV_FRAMING_ERROR_FLAG] = push && (fe_ff || stop_bad);
		ev[uart_rx_pkg::EV_OVR] = overflow;
		ev[uart_rx_pkg::EV_AUTO_BAUD_ENABLE] = ab_done;
		ev[uart_rx_pkg::EV_ADDR] = push && nine_bit && address_detect_enable_ff;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ist_ff <= '0;
		else if (ce)
			ist_ff <= (ist_wr ? ist_ff & ~wr_data[uart_rx_pkg::EV_W-1:0] : ist_ff) | ev;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			imask_ff <= '0;
		else if (imask_wr)
			imask_ff <= wr_data[uart_rx_pkg::EV_W-1:0];
	end

	// interrupt outputs registered to keep them glitch free
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_irq_ff <= 1'b0;
			irq_ff <= 1'b0;
		end
		else if (ce)
		begin
			rx_irq_ff <= level_met(rxisel_ff, cnt_ff);
			irq_ff <= |(ist_ff & imask_ff);
		end
	end

	// read data valid in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rd_data_ff <= 32'h0000_0000;
		else if (ce)
		begin
			rd_data_ff <= 32'h0000_0000;
			if (rd_en)
				case (addr)
					uart_rx_pkg::OFF_MODE: rd_data_ff <= {25'h0, mode_ff};
					uart_rx_pkg::OFF_STATUS: rd_data_ff <= {24'h0, rxisel_ff, address_detect_enable_ff,
						idle_flag, parity_error_flag_flag, framing_error_flag_flag, ovr_ff, avail};
					uart_rx_pkg::OFF_RXDATA: rd_data_ff <= {23'h0, avail ? head[8:0] : 9'h000};
					uart_rx_pkg::OFF_INT_STATUS: rd_data_ff <= {26'h0, ist_ff};
					uart_rx_pkg::OFF_INT_MASK: rd_data_ff <= {26'h0, imask_ff};
					uart_rx_pkg::OFF_BAUD_MEASURE: rd_data_ff <= {12'h0, baud_ff};
					default: rd_data_ff <= 32'h0000_0000;
				endcase
		end
	end

	assign rd_data = rd_data_ff;
	assign rx_irq_flag = rx_irq_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ovr_clear;
		ovr_clear_go && !overflow;
	endsequence
	sequence s_flushed;
		cnt_ff == 3'h0 && st_ff == st_idle && shift_ff == 9'h000;
	endsequence

	property p_loopback;
		ce |=> line_prev_ff == $past(mode_ff[uart_rx_pkg::MODE_RECEIVE_POLARITY_INVERT]
			^ (mode_ff[uart_rx_pkg::MODE_LOOPBACK] ? tx_loop_line : serial_receive_line));
	endproperty
	a_loopback: assert property (p_loopback) else $error("loopback source wrong");

	property p_auto_baud_enable_clear;
		ab_done && !mode_wr |=> !mode_ff[uart_rx_pkg::MODE_AUTO_BAUD_ENABLE] && !ab_meas_ff;
	endproperty
	a_auto_baud_enable_clear: assert property (p_auto_baud_enable_clear) else $error("auto-baud not cleared");

	property p_idle_level;
		ce && st_ff == st_idle && line_n |=> st_ff == st_idle;
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("start taken on idle level");

	property p_bit_ticks;
		ce && st_ff == st_data && baud_tick && tk_ff != tick_top(high_speed_select, 1'b0)
			&& !ovr_clear_go |=> tk_ff == $past(tk_ff) + 4'h1;
	endproperty
	a_bit_ticks: assert property (p_bit_ticks) else $error("bit tick count wrong");

	property p_level;
		$past(ce) |-> rx_irq_flag == $past((rxisel_ff == 2'h2) ? cnt_ff >= 3'h3
			: (rxisel_ff == 2'h1) ? cnt_ff >= 3'h2 : cnt_ff != 3'h0);
	endproperty
	a_level: assert property (p_level) else $error("receive interrupt level wrong");

	property p_addr;
		// a finished data character in address mode leaves the fill untouched
		ch_done && address_detect_enable_ff && nine_bit && !shift_ff[8] && !pop && !sta_wr
			|=> cnt_ff == $past(cnt_ff);
	endproperty
	a_addr: assert property (p_addr) else $error("data character stored in address mode");

	property p_ovr_hold;
		ovr_ff && !ovr_clear_go |=> ovr_ff;
	endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared by hardware");

	property p_flush;
		s_ovr_clear |=> s_flushed ##1 (cnt_ff <= 3'h1);
	endproperty
	a_flush: assert property (p_flush) else $error("buffer not flushed");

	property p_avail;
		ce && rd_en && addr == uart_rx_pkg::OFF_STATUS |=> rd_data[0] == $past(cnt_ff != 3'h0)
			&& rd_data[4] == $past(st_ff == st_idle && !ab_meas_ff && !ab_tail_ff);
	endproperty
	a_avail: assert property (p_avail) else $error("status flags wrong");
endmodule

//--- logic/uart_rx_pkg.sv
package uart_rx_pkg;
	// register byte offsets on the plain port
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_RXDATA = 8'h08;
	localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
	localparam logic [7:0] OFF_INT_MASK = 8'h10;
	localparam logic [7:0] OFF_BAUD_MEASURE = 8'h14;
	// mode control field positions
	localparam int MODE_LOOPBACK = 6;
	localparam int MODE_AUTO_BAUD_ENABLE = 5;
	localparam int MODE_RECEIVE_POLARITY_INVERT = 4;
	localparam int MODE_HIGH_SPEED_SELECT = 3;
	localparam int MODE_DATA_PARITY_SELECT_HI = 2;
	localparam int MODE_DATA_PARITY_SELECT_LO = 1;
	localparam int MODE_STOP_COUNT_SELECT = 0;
	// status control field positions
	localparam int STA_RXISEL_HI = 7;
	localparam int STA_RXISEL_LO = 6;
	localparam int STA_ADDRESS_DETECT_ENABLE = 5;
	localparam int STA_IDLE = 4;
	localparam int STA_PARITY_ERROR_FLAG = 3;
	localparam int STA_FRAMING_ERROR_FLAG = 2;
	localparam int STA_OVR = 1;
	localparam int STA_AVAIL = 0;
	// character formats
	localparam logic [1:0] FMT_9N = 2'h3;
	localparam logic [1:0] FMT_8O = 2'h2;
	localparam logic [1:0] FMT_8E = 2'h1;
	// receive interrupt modes
	localparam logic [1:0] RXI_3Q = 2'h2;
	localparam logic [1:0] RXI_HALF = 2'h1;
	// buffer of four characters; thresholds in characters
	localparam int BUF_DEPTH = 4;
	localparam logic [2:0] LVL_3Q = 3'h3;
	localparam logic [2:0] LVL_HALF = 3'h2;
	localparam logic [2:0] LVL_ONE = 3'h1;
	localparam logic [2:0] LVL_FULL = 3'h4;
	// last tick index of a bit and of half a bit
	localparam logic [3:0] TK_TOP_4X = 4'h3;
	localparam logic [3:0] TK_TOP_16X = 4'hf;
	localparam logic [3:0] TK_HALF_4X = 4'h1;
	localparam logic [3:0] TK_HALF_16X = 4'h7;
	// the sync character 0x55 shows five falling edges over eight bit times
	localparam logic [2:0] AUTO_BAUD_ENABLE_LAST_EDGE = 3'h5;
	localparam int MEAS_W = 20;
	// interrupt event bits
	localparam int EV_RX_LEVEL = 0;
	localparam int EV_PARITY_ERROR_FLAG = 1;
	localparam int EV_FRAMING_ERROR_FLAG = 2;
	localparam int EV_OVR = 3;
	localparam int EV_AUTO_BAUD_ENABLE = 4;
	localparam int EV_ADDR = 5;
	localparam int EV_W = 6;
endpackage

//--- verif/uart_line_model.sv
`timescale 1ns/10ps
module uart_line_model (
	input wire logic clk, // bench clock
	output logic baud_tick, // one tick every second cycle
	output logic line // serial line toward the receiver
);
	logic idle_lvl = 1'h1;
	// free-running baud clock; the receiver counts ticks, not cycles
	initial baud_tick = 1'h0;
	initial line = 1'h1;
	always @(posedge clk)
		baud_tick <= ~baud_tick;
	// idle level follows the polarity the bench has chosen
	task automatic set_idle(input logic lvl);
		idle_lvl = lvl;
		line <= lvl;
	endtask
	// start, nd data bits lsb first, parity, stops; bad[0] flips parity,
	// bad[1] pulls the first stop low, bad[2] the last one
	task automatic send(input logic [8:0] d, input int nd, par, stops, bad, tpb);
		logic [12:0] f;
		logic p;
		int n;
		f = 13'h0;
		p = par == 2;
		for (int i = 0; i < nd; i++)
		begin
			f[i + 1] = d[i];
			p = p ^ d[i];
		end
		n = nd + 1;
		if (par != 0)
		begin
			f[n] = p ^ bad[0];
			n++;
		end
		for (int s = 0; s < stops; s++)
		begin
			f[n] = 1'h1;
			n++;
		end
		if (bad[1])
			f[n - stops] = 1'h0;
		if (bad[2])
			f[n - 1] = 1'h0;
		@(posedge clk iff baud_tick);
		for (int i = 0; i < n; i++)
		begin
			line <= f[i] ~^ idle_lvl;
			repeat (tpb * 3 / 4) @(posedge clk iff baud_tick);
			// a bad stop returns to idle after its sample point, so no false start
			if (i >= n - stops)
				line <= idle_lvl;
			repeat (tpb / 4) @(posedge clk iff baud_tick);
		end
		line <= idle_lvl;
	endtask
endmodule

//--- verif/uart_receive_config_status_tb_top.sv
`timescale 1ns/10ps
module uart_receive_config_status_tb_top;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'h0;
	logic rd_en = 1'h0;
	logic lpb = 1'h0; // model feeds the loopback input, pin held idle
	logic ce = 1'h1;
	logic [31:0] rd_data;
	logic [31:0] v;
	logic rx_irq_flag;
	logic irq;
	logic tick;
	logic mline;
	logic [7:0] ic[4] = '{8'h80, 8'h40, 8'hc0, 8'h00};
	int lv[4] = '{3, 2, 1, 1};
	int errors = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	uart_line_model lm_u (.clk(clk), .baud_tick(tick), .line(mline));
	uart_receive_config_status dut_u (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.serial_receive_line(lpb ? 1'h1 : mline),
		.tx_loop_line(lpb ? mline : 1'h1),
		.baud_tick(tick),
		.rx_irq_flag(rx_irq_flag),
		.irq(irq)
	);
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic flag(input logic f, e, input string m);
		chk({31'h0, f}, {31'h0, e}, m);
	endtask
	// one-cycle strobes, changed just after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdq(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1;
		v = rd_data;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		rdq(a);
		chk(v, e, m);
	endtask
	task automatic rs(input logic [31:0] e, input string m);
		rd(uart_rx_pkg::OFF_STATUS, e, m);
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 1000 && irq !== 1'h1; i++)
			@(posedge clk);
		check_count++;
		if (irq !== 1'h1)
		begin
			errors++;
			$display("wrong value at %0t: no interrupt", $time);
			finish_test();
		end
	endtask
	// one character in a given mode, then status and data
	task automatic fmt(input logic [31:0] md, input logic [8:0] d,
		input int nd, par, stops, bad, tpb, input logic [31:0] es);
		wr(uart_rx_pkg::OFF_MODE, md);
		lm_u.send(d, nd, par, stops, bad, tpb);
		repeat (4) @(posedge clk);
		rs(es, "fmt sta");
		rd(uart_rx_pkg::OFF_RXDATA, {23'h0, d}, "fmt data");
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		rd(uart_rx_pkg::OFF_MODE, 32'h0, "mode rst");
		rs(32'h10, "sta rst");
		rd(8'hfc, 32'h0, "unmapped");
		wr(uart_rx_pkg::OFF_STATUS, 32'h1f);
		rs(32'h10, "ro bits");
		// a write while the enable is low must not land
		ce <= 1'h0;
		wr(uart_rx_pkg::OFF_MODE, 32'h1);
		ce <= 1'h1;
		rd(uart_rx_pkg::OFF_MODE, 32'h0, "frozen");
		$display("test reset done");
		// idle flag drops while a character is on the line
		fork
			lm_u.send(9'h0a5, 8, 0, 1, 0, 16);
			begin
				repeat (100) @(posedge clk);
				rs(32'h0, "busy");
			end
		join
		repeat (4) @(posedge clk);
		flag(rx_irq_flag, 1'h1, "rxi one");
		rs(32'h11, "avail");
		rd(uart_rx_pkg::OFF_RXDATA, 32'ha5, "data");
		rs(32'h10, "empty");
		flag(rx_irq_flag, 1'h0, "rxi none");
		$display("test basic done");
		fmt(32'h6, 9'h1c3, 9, 0, 1, 0, 16, 32'h11);
		fmt(32'h4, 9'h03c, 8, 2, 1, 0, 16, 32'h11);
		fmt(32'h2, 9'h03c, 8, 1, 1, 1, 16, 32'h19);
		fmt(32'h4, 9'h03d, 8, 1, 1, 0, 16, 32'h19);
		fmt(32'h0, 9'h0f0, 8, 0, 1, 2, 16, 32'h15);
		fmt(32'h1, 9'h00f, 8, 0, 2, 4, 16, 32'h15);
		fmt(32'h8, 9'h05a, 8, 0, 1, 0, 4, 32'h11);
		$display("test formats done");
		// ninth bit clear is dropped only in nine-bit format
		wr(uart_rx_pkg::OFF_STATUS, 32'h20);
		wr(uart_rx_pkg::OFF_MODE, 32'h6);
		lm_u.send(9'h0aa, 9, 0, 1, 0, 16);
		fmt(32'h6, 9'h1bb, 9, 0, 1, 0, 16, 32'h31);
		fmt(32'h0, 9'h0aa, 8, 0, 1, 0, 16, 32'h31);
		wr(uart_rx_pkg::OFF_MODE, 32'h8);
		$display("test address done");
		// fill under every threshold code, then drain in order
		for (int j = 0; j < 4; j++)
		begin
			wr(uart_rx_pkg::OFF_STATUS, {24'h0, ic[j]});
			for (int k = 1; k <= 4; k++)
			begin
				lm_u.send(9'(k), 8, 0, 1, 0, 4);
				repeat (4) @(posedge clk);
				flag(rx_irq_flag, k >= lv[j], "rxi lvl");
			end
			for (int k = 1; k <= 4; k++)
				rd(uart_rx_pkg::OFF_RXDATA, 32'(k), "drain");
		end
		$display("test thresholds done");
		// fifth character overflows; irq follows the mask
		wr(uart_rx_pkg::OFF_STATUS, 32'h0);
		for (int k = 1; k <= 5; k++)
			lm_u.send(9'(k), 8, 0, 1, 0, 4);
		repeat (4) @(posedge clk);
		rs(32'h13, "ovr set");
		flag(irq, 1'h0, "masked");
		wr(uart_rx_pkg::OFF_INT_MASK, 32'h08);
		repeat (2) @(posedge clk);
		flag(irq, 1'h1, "irq on");
		rs(32'h13, "ovr held");
		wr(uart_rx_pkg::OFF_STATUS, 32'h0);
		rs(32'h10, "flushed");
		rd(uart_rx_pkg::OFF_RXDATA, 32'h0, "no data");
		rd(uart_rx_pkg::OFF_INT_STATUS, 32'h2f, "events");
		wr(uart_rx_pkg::OFF_INT_STATUS, 32'h2f);
		rd(uart_rx_pkg::OFF_INT_STATUS, 32'h0, "ev clr");
		flag(irq, 1'h0, "irq off");
		$display("test overrun done");
		// sync character: 8 bit times of 32 cycles between first and fifth fall
		wr(uart_rx_pkg::OFF_INT_MASK, 32'h10);
		wr(uart_rx_pkg::OFF_MODE, 32'h20);
		lm_u.send(9'h055, 8, 0, 1, 0, 16);
		wait_irq();
		rd(uart_rx_pkg::OFF_MODE, 32'h0, "auto_baud_enable clr");
		rs(32'h10, "sync kept out");
		rdq(uart_rx_pkg::OFF_BAUD_MEASURE);
		chk({31'h0, v >= 32'hfe && v <= 32'h101}, 32'h1, "baud");
		wr(uart_rx_pkg::OFF_INT_STATUS, 32'h10);
		wr(uart_rx_pkg::OFF_INT_MASK, 32'h0);
		$display("test autobaud done");
		lpb <= 1'h1;
		fmt(32'h40, 9'h03e, 8, 0, 1, 0, 16, 32'h11);
		wr(uart_rx_pkg::OFF_MODE, 32'h0);
		lm_u.send(9'h077, 8, 0, 1, 0, 16);
		rs(32'h10, "pin only");
		lpb <= 1'h0;
		$display("test loopback done");
		// line and inversion flip two cycles apart; let that false start die before sending
		lm_u.set_idle(1'h0);
		wr(uart_rx_pkg::OFF_MODE, 32'h10);
		repeat (20) @(posedge clk);
		fmt(32'h10, 9'h069, 8, 0, 1, 0, 16, 32'h11);
		$display("test polarity done");
		finish_test();
	end
endmodule
